// ===== alu_core.sv
// 8-bit arithmetic, logic and rotate unit
`timescale 1ns/1ps
module alu_core
  import core_pkg::*;
(
  input  wire alu_op_t    op,
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic       cin,
  output logic [7:0]      res,
  output logic            co,
  output logic            ac,
  output logic            ov
);

  // =====================================================================
  // shared adder: subtract is a plus inverted b plus one
  // =====================================================================
  wire       isSub  = (op == ALU_SUB) || (op == ALU_SBC);
  wire [7:0] addB   = isSub ? ~b : b;
  wire       addCin = (op == ALU_SUB) ? 1'b1 : ((op == ALU_ADC) || (op == ALU_SBC)) ? cin : 1'b0;
  wire [8:0] sum    = {1'b0, a} + {1'b0, addB} + {8'h00, addCin};
  wire [4:0] nib    = {1'b0, a[3:0]} + {1'b0, addB[3:0]} + {4'h0, addCin};

  // =====================================================================
  // function select
  // =====================================================================
  always_comb begin
    res = sum[7:0];
    co  = sum[8];          // carry out; low after subtract means borrow
    ac  = nib[4];
    ov  = (a[7] == addB[7]) && (sum[7] != a[7]);
    case (op)
      ALU_AND:   res = a & b;
      ALU_OR:    res = a | b;
      ALU_XOR:   res = a ^ b;
      ALU_NOT:   res = ~b;
      ALU_INC:   res = b + 8'h01;
      ALU_MINUS1: res = b - 8'h01;
      ALU_RORP:  res = {b[0], b[7:1]};
      ALU_ROLP:  res = {b[6:0], b[7]};
      ALU_RORC: begin
        res = {cin, b[7:1]};
        co  = b[0];
      end
      ALU_ROLC: begin
        res = {b[6:0], cin};
        co  = b[7];
      end
      ALU_PASSA: res = a;
      ALU_PASSB: res = b;
      default:   res = sum[7:0];
    endcase
  end

endmodule

// ===== core_cfg.svh
// fixed offsets, reset values and timing counts of the execution core
`ifndef CORE_CFG_SVH
`define CORE_CFG_SVH

// =====================================================================
// instruction cycle timing
// =====================================================================
`define CLK_PER_ICYCLE 4      // system clocks per instruction cycle
`define PHASE_FETCH    2'h0   // instruction word latched
`define PHASE_READ     2'h1   // data memory operand latched
`define PHASE_WRITE    2'h2   // result staged for data memory
`define PHASE_LAST     2'h3   // commit of core state

// =====================================================================
// addresses and reset values
// =====================================================================
`define PC_LOW_ADDR    8'h02           // data address of program counter low byte
`define IRQ_VECTOR     32'h0000_0004   // interrupt entry address
`define RST_PC         32'h0000_0000   // first fetch after reset
`define RST_WREG       8'h00           // working register after reset
`define PC_W_DEF       11              // program counter width
`define STACK_DEPTH_DEF 8              // return stack entries

`endif

// ===== core_exec.sv
// instruction sequencing and execution of the 8-bit core
`timescale 1ns/1ps
`include "core_cfg.svh"
module core_exec
  import core_pkg::*;
#(
  parameter int PC_W        = `PC_W_DEF,
  parameter int STACK_DEPTH = `STACK_DEPTH_DEF
) (
  input  wire logic            mclk,
  input  wire logic            rstn,
  output logic [PC_W-1:0]      pmAddr,
  input  wire logic [15:0]     pmData,
  output logic [7:0]           dmAddr,
  input  wire logic [7:0]      dmRdata,
  output logic [7:0]           dmWdata,
  output logic                 dmWe,
  input  wire logic            irqReq,
  output logic                 irqAck,
  input  wire logic            wakeReq,
  output logic                 powerDown,
  output logic                 wdtClear,
  output logic                 globalIrqEnable,
  output logic [7:0]           workingReg,
  output logic [3:0]           statusFlags,
  output logic [7:0]           tableHigh,
  output logic [1:0]           cyclePhase
);

  localparam int SP_W = $clog2(STACK_DEPTH + 1);   // pointer counts 0..depth
  localparam int AW   = $clog2(STACK_DEPTH);

  // =====================================================================
  // state
  // =====================================================================
  state_t            state_q, stateD;     // sequencer
  logic [1:0]        phase_q, phaseD;     // clock within instruction cycle
  logic [15:0]       instr_q;             // current instruction word
  logic [7:0]        operand_q;           // data memory operand
  logic [7:0]        wreg_q;              // working register
  logic              zf_q, cf_q, acf_q, ovf_q;
  logic [PC_W-1:0]   pc_q;                // address of current instruction
  logic [PC_W-1:0]   pmAddr_q;            // next program memory fetch
  logic [7:0]        dmAddr_q, dmWdata_q;
  logic              dmWe_q;
  logic              gie_q;               // global interrupt enable
  logic [SP_W-1:0]   sp_q;                // stack fill level
  logic              tabPend_q;           // extra cycle carries table data
  logic [7:0]        tblLow_q, tblHigh_q;
  logic              wdtClear_q, irqAck_q;

  // =====================================================================
  // instruction fields and class decode
  // =====================================================================
  wire opcode_t opc   = opcode_t'(instr_q[15:12]);
  wire misc_t   msub  = misc_t'(instr_q[10:8]);
  wire          toMem = instr_q[11];
  wire [2:0]    sub   = instr_q[10:8];
  wire [7:0]    mAddr = instr_q[7:0];

  wire isMisc   = (opc == OP_MISC);
  wire isSubExit = isMisc && (msub == MS_SUBEXIT);
  wire isIrqExit = isMisc && (msub == MS_IRQEXIT);
  wire isHalt   = isMisc && (msub == MS_HALT);
  wire isClrWdt = isMisc && (msub == MS_CLRWDT);
  wire isTab    = isMisc && (msub == MS_TABRD);
  wire isJump   = (opc == OP_JUMP);
  wire isCall   = (opc == OP_CALL);
  wire isBit    = (opc == OP_BSET) || (opc == OP_BCLR);
  wire isArithM = (opc == OP_ADD) || (opc == OP_ADC) || (opc == OP_SUB) || (opc == OP_SBC);
  wire isAluM   = isArithM || (opc == OP_LOGIC) || (opc == OP_ROTC);
  wire immArith = (opc == OP_IMM) && (sub < 3'h2);
  wire immLogic = (opc == OP_IMM) && (sub >= 3'h2) && (sub <= 3'h4);

  // alu function for the current class
  function automatic alu_op_t aluSel(input opcode_t o, input logic [2:0] s);
    alu_op_t f;
    f = ALU_PASSB;
    case (o)
      OP_ADD:   f = ALU_ADD;
      OP_ADC:   f = ALU_ADC;
      OP_SUB:   f = ALU_SUB;
      OP_SBC:   f = ALU_SBC;
      OP_LOGIC: f = alu_op_t'({1'b0, s} + 4'h4);
      OP_ROTC:  f = s[0] ? ALU_ROLC : ALU_RORC;
      OP_MOVMA: f = ALU_PASSA;
      OP_IMM: begin
        case (s)
          3'h0:    f = ALU_ADD;
          3'h1:    f = ALU_SUB;
          3'h2:    f = ALU_AND;
          3'h3:    f = ALU_OR;
          3'h4:    f = ALU_XOR;
          default: f = ALU_PASSB;
        endcase
      end
      default:  f = ALU_PASSB;
    endcase
    return f;
  endfunction

  // =====================================================================
  // datapath
  // =====================================================================
  wire          pcLowHit = (mAddr == `PC_LOW_ADDR);
  wire [7:0]    aluB    = (opc == OP_IMM) ? mAddr : operand_q;
  wire alu_op_t aluOp   = aluSel(opc, sub);
  wire [7:0]    aluRes;
  wire          aluCo, aluAc, aluOv;
  wire [7:0]    bitMask = 8'h01 << sub;
  wire [7:0]    bitRes  = (opc == OP_BSET) ? (operand_q | bitMask) : (operand_q & ~bitMask);
  wire [7:0]    result  = isBit ? bitRes : aluRes;

  // first alu operand is always the working register
  alu_core u_alu (
    .op  (aluOp),
    .a   (wreg_q),
    .b   (aluB),
    .cin (cf_q),
    .res (aluRes),
    .co  (aluCo),
    .ac  (aluAc),
    .ov  (aluOv)
  );

  // destination select for transfers and alu results
  wire memWr = (isAluM && toMem) || (opc == OP_MOVMA) || isBit;
  wire accWr = (isAluM && !toMem) || (opc == OP_MOVAM) || (opc == OP_IMM);
  wire pcLowWr = memWr && pcLowHit;

  // flag classes: full arithmetic, zero only, carry only
  wire updArith = isArithM || immArith;
  wire updZ     = updArith || immLogic || ((opc == OP_LOGIC) && (sub < 3'h6));
  wire updC     = updArith || (opc == OP_ROTC);

  // byte test or bit test; bit 11 picks skip-if-set
  wire skipTaken = ((opc == OP_SZ) && (operand_q == 8'h00)) ||
                   ((opc == OP_SBIT) && (operand_q[sub] == toMem));

  // instructions that need a second cycle
  wire needExtra = isJump || isCall || isSubExit || isIrqExit || isTab || pcLowWr || skipTaken;

  // =====================================================================
  // program counter and return stack
  // =====================================================================
  wire [PC_W-1:0] stackRd;
  wire [PC_W-1:0] pcPlus1 = pc_q + PC_W'(1);
  wire [PC_W-1:0] pcPlus2 = pc_q + PC_W'(2);
  wire [PC_W-1:0] tblAddr = {pc_q[PC_W-1:8], wreg_q};  // table lies in current page
  wire            stackFull  = (sp_q == SP_W'(STACK_DEPTH));
  wire            stackEmpty = (sp_q == '0);
  wire            lastPh  = (phase_q == `PHASE_LAST);
  wire            runEnd  = (state_q == ST_RUN) && lastPh;
  wire            extraEnd = (state_q == ST_EXTRA) && lastPh;

  wire [PC_W-1:0] nextPc = (isJump || isCall) ? instr_q[PC_W-1:0] :
                           (isSubExit || isIrqExit) ? stackRd :
                           pcLowWr            ? {pc_q[PC_W-1:8], result} :
                           skipTaken          ? pcPlus2 : pcPlus1;

  // interrupt entry only at an ordinary instruction boundary
  wire takeIrq  = runEnd && !needExtra && !isHalt && irqReq && gie_q && !stackFull;
  wire [PC_W-1:0] pcD = takeIrq ? PC_W'(`IRQ_VECTOR) : nextPc;
  // push on call or interrupt entry, pop on either return
  wire pushEn   = runEnd && ((isCall && !stackFull) || takeIrq);
  wire popEn    = runEnd && (isSubExit || isIrqExit) && !stackEmpty;
  wire [PC_W-1:0] pushData = isCall ? pcPlus1 : nextPc;

  pc_stack_mem #(
    .DW    (PC_W),
    .DEPTH (STACK_DEPTH),
    .AW    (AW)
  ) u_stack (
    .mclk  (mclk),
    .we    (pushEn),
    .waddr (AW'(sp_q)),
    .wdata (pushData),
    .raddr (AW'(sp_q - SP_W'(1))),
    .rdata (stackRd)
  );

  // =====================================================================
  // sequencer
  // =====================================================================
  always_comb begin
    stateD = state_q;
    case (state_q)
      ST_SLEEP: stateD = wakeReq ? ST_RUN : ST_SLEEP;
      ST_EXTRA: stateD = lastPh ? ST_RUN : ST_EXTRA;
      ST_RUN: begin
        if (lastPh) begin
          // halt parks the core, ordinary ones stay in run
          stateD = isHalt ? ST_SLEEP : (needExtra || takeIrq) ? ST_EXTRA : ST_RUN;
        end
      end
      default:  stateD = ST_RUN;
    endcase
  end

  // phase wraps every four clocks, held at fetch while asleep
  assign phaseD = (state_q == ST_SLEEP) ? `PHASE_FETCH : phase_q + 2'h1;

  // sequencer registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_RUN;
      phase_q <= `PHASE_FETCH;
    end else begin
      state_q <= stateD;
      phase_q <= phaseD;
    end
  end

  // instruction and operand capture
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      instr_q   <= 16'h0000;
      dmAddr_q  <= 8'h00;
      operand_q <= 8'h00;
    end else if (state_q == ST_RUN && phase_q == `PHASE_FETCH) begin
      instr_q  <= pmData;
      dmAddr_q <= pmData[7:0];
    end else if (state_q == ST_RUN && phase_q == `PHASE_READ) begin
      operand_q <= pcLowHit ? pc_q[7:0] : dmRdata;
    end
  end

  // =====================================================================
  // data memory write, staged so the strobe is a clean register
  // =====================================================================
  // table low byte lands in the addressed data location
  wire dmWeD = (phase_q == `PHASE_WRITE) &&
               (((state_q == ST_RUN) && memWr && !pcLowHit) || ((state_q == ST_EXTRA) && tabPend_q));
  wire [7:0] dmWdataD = (state_q == ST_EXTRA) ? tblLow_q : result;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dmWe_q    <= 1'b0;
      dmWdata_q <= 8'h00;
    end else begin
      dmWe_q <= dmWeD;
      if (phase_q == `PHASE_WRITE) begin
        dmWdata_q <= dmWdataD;
      end
    end
  end

  // =====================================================================
  // working register and flags, committed at the last phase
  // =====================================================================
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wreg_q <= `RST_WREG;
      {zf_q, cf_q, acf_q, ovf_q} <= 4'h0;
    end else if (runEnd) begin
      if (accWr) begin
        wreg_q <= result;
      end
      if (updZ) begin
        zf_q <= (result == 8'h00);
      end
      if (updC) begin
        cf_q <= aluCo;
      end
      if (updArith) begin
        acf_q <= aluAc;
        ovf_q <= aluOv;
      end
    end
  end

  // =====================================================================
  // program flow registers
  // =====================================================================
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pc_q     <= PC_W'(`RST_PC);
      pmAddr_q <= PC_W'(`RST_PC);
      sp_q     <= '0;
      gie_q    <= 1'b0;
    end else if (runEnd) begin
      pc_q     <= pcD;
      // table read borrows the next fetch slot
      pmAddr_q <= isTab ? tblAddr : pcD;
      sp_q     <= pushEn ? sp_q + SP_W'(1) : popEn ? sp_q - SP_W'(1) : sp_q;
      gie_q    <= isIrqExit ? 1'b1 : takeIrq ? 1'b0 : gie_q;
    end else if (extraEnd) begin
      pmAddr_q <= pc_q;
    end
  end

  // table capture and one-clock pulses
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tabPend_q  <= 1'b0;
      tblLow_q   <= 8'h00;
      tblHigh_q  <= 8'h00;
      wdtClear_q <= 1'b0;
      irqAck_q   <= 1'b0;
    end else begin
      tabPend_q <= (runEnd && isTab) ? 1'b1 : extraEnd ? 1'b0 : tabPend_q;
      if (state_q == ST_EXTRA && phase_q == `PHASE_FETCH && tabPend_q) begin
        {tblHigh_q, tblLow_q} <= pmData;
      end
      wdtClear_q <= runEnd && isClrWdt;
      irqAck_q   <= takeIrq;
    end
  end

  // =====================================================================
  // outputs
  // =====================================================================
  assign pmAddr          = pmAddr_q;
  assign dmAddr          = dmAddr_q;
  assign dmWdata         = dmWdata_q;
  assign dmWe            = dmWe_q;
  assign irqAck          = irqAck_q;
  assign powerDown       = (state_q == ST_SLEEP);
  assign wdtClear        = wdtClear_q;
  assign globalIrqEnable = gie_q;
  assign workingReg      = wreg_q;
  assign statusFlags     = {ovf_q, acf_q, cf_q, zf_q};
  assign tableHigh       = tblHigh_q;
  assign cyclePhase      = phase_q;

  // =====================================================================
  // assertions
  // =====================================================================
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_phase_step: assert property ((state_q != ST_SLEEP) |=> phase_q == 2'($past(phase_q) + 2'h1))
    else $error("phase did not advance by one");
  a_single_cycle: assert property ((runEnd && !needExtra && !isHalt && !takeIrq) |=>
    (state_q == ST_RUN) && (phase_q == `PHASE_FETCH))
    else $error("ordinary instruction took an extra cycle");
  a_branch_two: assert property ((runEnd && (isJump || isCall || isSubExit || isIrqExit || isTab)) |=>
    (state_q == ST_EXTRA) [*4] ##1 (state_q == ST_RUN))
    else $error("branch class did not take exactly two cycles");
  a_pclow_branch: assert property ((runEnd && pcLowWr) |=>
    (state_q == ST_EXTRA) && (pc_q[7:0] == $past(result)))
    else $error("counter low byte write did not branch");
  a_skip_cost: assert property ((runEnd && ((opc == OP_SZ) || (opc == OP_SBIT))) |=>
    ((state_q == ST_EXTRA) == $past(skipTaken)) && (pc_q == ($past(skipTaken) ? $past(pcPlus2) : $past(pcPlus1))))
    else $error("skip cost or target wrong");
  a_add_carry: assert property ((runEnd && (opc == OP_ADD)) |=>
    cf_q == (($past({1'b0, wreg_q}) + $past({1'b0, operand_q})) > 9'h0ff))
    else $error("add carry wrong");
  a_logic_zero: assert property ((runEnd && (opc == OP_LOGIC) && (sub < 3'h4) && !toMem) |=>
    zf_q == (wreg_q == 8'h00))
    else $error("logic zero flag disagrees with result");
  a_bit_only: assert property ((dmWe_q && (state_q == ST_RUN) && isBit) |->
    (((dmWdata_q ^ operand_q) & ~bitMask) == 8'h00) && (dmWdata_q[sub] == (opc == OP_BSET)))
    else $error("bit operation changed other bits");
  a_ret_target: assert property ((runEnd && isSubExit && !stackEmpty) |=>
    (pc_q == $past(stackRd)) && (sp_q == $past(sp_q) - SP_W'(1)))
    else $error("return did not pop the saved address");
  a_interrupt_exit_reenable_gie: assert property ((runEnd && (isSubExit || isIrqExit)) |=> gie_q == ($past(isIrqExit) || $past(gie_q)))
    else $error("global enable wrong after return");

  c_call: cover property (runEnd && isCall ##5 runEnd && isSubExit);
  c_skip: cover property (runEnd && skipTaken);
  c_irq: cover property (takeIrq);
  c_sleep: cover property (powerDown ##1 wakeReq);

endmodule

// ===== core_pkg.sv
// shared types of the execution core
package core_pkg;

  // =====================================================================
  // instruction classes, taken from instruction bits 15:12
  // =====================================================================
  typedef enum logic [3:0] {
    OP_MISC, OP_MOVAM, OP_MOVMA, OP_CALL, OP_ADD, OP_ADC, OP_SUB, OP_SBC,
    OP_LOGIC, OP_ROTC, OP_IMM, OP_BCLR, OP_BSET, OP_SZ, OP_SBIT, OP_JUMP
  } opcode_t;

  // sub-operations of the misc class, bits 10:8
  typedef enum logic [2:0] {
    MS_NOP, MS_SUBEXIT, MS_IRQEXIT, MS_HALT, MS_CLRWDT, MS_TABRD, MS_RSV6, MS_RSV7
  } misc_t;

  // alu functions
  typedef enum logic [3:0] {
    ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_AND, ALU_OR, ALU_XOR, ALU_NOT,
    ALU_INC, ALU_MINUS1, ALU_RORP, ALU_ROLP, ALU_RORC, ALU_ROLC, ALU_PASSA, ALU_PASSB
  } alu_op_t;

  // sequencer states
  typedef enum logic [1:0] {ST_RUN, ST_EXTRA, ST_SLEEP} state_t;

endpackage

// ===== mem_model.sv
// behavioural program and data memory on the far side of the core
`timescale 1ns/1ps
module mem_model (
  input  wire logic        mclk,
  input  wire logic [10:0] pmAddr,
  output logic [15:0]      pmData,
  input  wire logic [7:0]  dmAddr,
  output logic [7:0]       dmRdata,
  input  wire logic [7:0]  dmWdata,
  input  wire logic        dmWe
);
  // =====================================================================
  // storage, loaded by the bench before reset is released
  // =====================================================================
  logic [15:0] prog [0:2047]; // program words
  logic [7:0]  data [0:255];  // data bytes
  // reads are combinational because the core samples mid-cycle
  assign pmData  = prog[pmAddr];
  assign dmRdata = data[dmAddr];
  // a byte changes only on the strobe edge
  always @(posedge mclk) begin
    if (dmWe === 1'b1) begin
      data[dmAddr] <= dmWdata;
    end
  end
endmodule

// ===== pc_stack_mem.sv
// return address store with registered read data
`timescale 1ns/1ps
module pc_stack_mem #(
  parameter int DW    = 11,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic          mclk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic [DW-1:0]      rdata
);

  // =====================================================================
  // storage; no reset, contents are meaningless until pushed
  // =====================================================================
  logic [DW-1:0] mem [DEPTH];   // entries
  logic [DW-1:0] rdata_q;       // read register

  // write port
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // read port, one clock latency
  always_ff @(posedge mclk) begin
    rdata_q <= mem[raddr];
  end

  assign rdata = rdata_q;

endmodule

// ===== testbench.sv
// self-checking bench: runs a short program and checks every data write
`timescale 1ns/1ps
module testbench;
  import core_pkg::*;
  typedef struct {logic [7:0] a; logic [7:0] d; int t;} note_t;
  logic        mclk, rstn, irqReq, wakeReq; // clock, reset, tied requests
  logic [10:0] pmAddr;                       // program address
  logic [15:0] pmData;                       // program word
  logic [7:0]  dmAddr, dmRdata, dmWdata;     // data memory bus
  logic        dmWe, powerDown;              // strobe and halt state
  logic [7:0]  workingReg;                   // accumulator view
  logic [3:0]  statusFlags;                  // {ov, ac, c, z} view
  logic [1:0]  cyclePhase;                   // phase within instruction cycle
  logic        gie;                          // global interrupt enable view
  logic [7:0]  r [0:5];                      // random operands
  logic [8:0]  sum;                          // add result with carry
  note_t       notes [$];                    // expected writes, oldest first
  note_t       n;                            // note being compared
  int          mismatches, num_checks, cyc;  // counters
  core_exec core_exec_i (.mclk(mclk), .rstn(rstn), .pmAddr(pmAddr), .pmData(pmData), .dmAddr(dmAddr),
    .dmRdata(dmRdata), .dmWdata(dmWdata), .dmWe(dmWe), .irqReq(irqReq), .irqAck(), .wakeReq(wakeReq),
    .powerDown(powerDown), .wdtClear(), .globalIrqEnable(gie), .workingReg(workingReg),
    .statusFlags(statusFlags), .tableHigh(), .cyclePhase(cyclePhase));
  mem_model mem_model_i (.mclk(mclk), .pmAddr(pmAddr), .pmData(pmData), .dmAddr(dmAddr),
    .dmRdata(dmRdata), .dmWdata(dmWdata), .dmWe(dmWe));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // =====================================================================
  // shared helpers
  // =====================================================================
  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic note(input logic [7:0] a, input logic [7:0] d, input int t);
    notes.push_back('{a, d, t});
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // =====================================================================
  // monitor: each write strobe takes the oldest note; edge count gives timing
  // =====================================================================
  always @(posedge mclk) begin
    if (rstn === 1'b1) begin
      if (dmWe === 1'b1) begin
        if (notes.size() == 0) begin
          mismatches++;
          $display("[FAIL] %0t write with nothing expected at %h", $time, dmAddr);
        end else begin
          n = notes.pop_front();
          check8(dmAddr, n.a, "write address");
          check8(dmWdata, n.d, "write data");
          check8(8'(cyc), 8'(n.t), "write edge");
        end
      end
      cyc++;
      // hang guard: program ends well before this
      if (cyc == 300) begin
        mismatches++;
        give_verdict();
      end
    end
  end
  // =====================================================================
  // stimulus: program image, operands and expected writes
  // =====================================================================
  initial begin
    rstn = 1'b0;
    irqReq = 1'b0;
    wakeReq = 1'b0;
    cyc = 0;
    void'($urandom(32'had4a));
    for (int i = 0; i < 2048; i++) mem_model_i.prog[i] = 16'h0000;
    for (int i = 0; i < 256; i++) mem_model_i.data[i] = 8'h00;
    for (int i = 0; i < 6; i++) r[i] = 8'($urandom);
    mem_model_i.data[8'h10] = r[0];
    mem_model_i.data[8'h11] = r[1];
    mem_model_i.data[8'h12] = r[2];
    mem_model_i.data[8'h14] = r[3];
    mem_model_i.data[8'h17] = r[4];
    mem_model_i.data[8'h18] = r[5];
    // load A, add to memory, xor to memory, call, bit set, skip, jump
    mem_model_i.prog[0] = 16'h1010;
    mem_model_i.prog[1] = 16'h4811;
    mem_model_i.prog[2] = 16'h8a12;
    mem_model_i.prog[3] = 16'h3010;
    mem_model_i.prog[4] = 16'hc514;
    mem_model_i.prog[5] = 16'hd015;
    mem_model_i.prog[6] = 16'h2016;
    mem_model_i.prog[7] = 16'hf020;
    // subroutine: store A, return
    mem_model_i.prog[16] = 16'h2013;
    mem_model_i.prog[17] = 16'h0100;
    // jump target: rotate through carry, increment, halt
    mem_model_i.prog[32] = 16'h9817;
    mem_model_i.prog[33] = 16'h8c18;
    mem_model_i.prog[34] = 16'h0300;
    sum = {1'b0, r[0]} + {1'b0, r[1]};
    note(8'h11, sum[7:0], 7);
    note(8'h12, r[0] ^ r[2], 11);
    note(8'h13, r[0], 23);
    note(8'h14, r[3] | 8'h20, 35);
    note(8'h17, {sum[8], r[4][7:1]}, 55);
    note(8'h18, r[5] + 8'h01, 59);
    repeat (6) @(posedge mclk);
    #1 rstn = 1'b1;
    repeat (90) @(posedge mclk);
    #1;
    check8(workingReg, r[0], "working register");
    check8({7'h00, powerDown}, 8'h01, "power down");
    check8(8'(notes.size()), 8'h00, "writes left");
    check8({4'h0, statusFlags}, {4'h0, (r[0][7] == r[1][7]) && (sum[7] != r[0][7]),
      ({1'b0, r[0][3:0]} + {1'b0, r[1][3:0]}) > 5'h0f, r[4][0], (r[5] + 8'h01) == 8'h00}, "flags");
    check8({6'h00, cyclePhase}, 8'h00, "phase held asleep");
    check8({7'h00, gie}, 8'h00, "global enable");
    give_verdict();
  end
endmodule
